// [dv/vacuum_gripper_command_regs_tb.sv]
// Self-checking bench for the gripper register bank.
`timescale 1ns/1ps
module vacuum_gripper_command_regs_tb;
    logic       core_clk_i      = 1'b0;
    logic       reset_i         = 1'b1;
    logic [3:0] addr_i          = 4'h0;
    logic [7:0] wdata_i         = 8'h00;
    logic       wr_i            = 1'b0;
    logic       rd_i            = 1'b0;
    logic [7:0] pressure_i;
    logic [7:0] rdata_o;
    logic       vac_gen_on_o;
    logic       release_valve_o;
    logic [3:0] rsv [4]         = '{4'h1, 4'h2, 4'h6, 4'hf};
    int         num_errors      = 0;
    int         samples_checked = 0;
    int         cyc             = 0;

    always #12.5 core_clk_i = ~core_clk_i;

    // A short tick keeps the grip windows to 200 cycles or less.
    vacuum_gripper_command_regs #(.TICK_CYCLES(22'd10)) dut (
        .core_clk_i(core_clk_i), .reset_i(reset_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .pressure_i(pressure_i),
        .rdata_o(rdata_o), .vac_gen_on_o(vac_gen_on_o),
        .release_valve_o(release_valve_o));
    vacuum_plant plant (.core_clk_i(core_clk_i), .gen_on_i(vac_gen_on_o),
        .valve_open_i(release_valve_o), .pressure_o(pressure_i));

    // ========
    // Tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge core_clk_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rc(input logic [3:0] a, input logic [7:0] exp);
        @(posedge core_clk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge core_clk_i);
        rd_i <= 1'b0;
        @(negedge core_clk_i);
        chk(rdata_o, exp);
    endtask : rc
    task automatic hold(input int n, input bit s, input logic v);
        repeat (n) @(negedge core_clk_i);
        chk({7'h0, s ? release_valve_o : vac_gen_on_o}, {7'h0, v});
    endtask : hold
    task automatic wt(input bit s, input logic v);
        int i;
        for (i = 0; i < 500; i++) begin
            @(negedge core_clk_i);
            if ((s ? release_valve_o : vac_gen_on_o) === v) break;
        end
        hold(0, s, v);
    endtask : wt
    task automatic wrap_up;
        $display("checked %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up

    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 30000) begin
            num_errors++;
            wrap_up();
        end
    end

    // ========
    // Tests
    initial begin
        repeat (6) @(posedge core_clk_i);
        reset_i <= 1'b0;
        rc(4'h0, 8'h00);
        rc(4'h2, 8'h00);
        foreach (rsv[k]) wr(rsv[k], 8'hff);
        wr(4'h0, 8'he0);
        rc(4'h0, 8'h00);
        rc(4'h1, 8'h00);
        rc(4'h5, 8'h00);
        rc(4'hf, 8'h00);
        rc(4'h4, 8'h64);
        wr(4'h3, 8'h30);
        wr(4'h5, 8'h50);
        wr(4'h4, 8'h00);
        wr(4'h0, 8'h0b);
        wt(0, 1'b1);
        wt(0, 1'b0);
        rc(4'h0, 8'hbb);
        rc(4'h3, 8'h30);
        wr(4'h0, 8'h03);
        wr(4'h3, 8'h00);
        wr(4'h0, 8'h0b);
        hold(60, 0, 1'b1);
        rc(4'h1, 8'h01);
        wr(4'h0, 8'h03);
        hold(4, 0, 1'b0);
        wr(4'h5, 8'h05);
        wr(4'h4, 8'h02);
        wr(4'h0, 8'h0b);
        hold(12, 0, 1'b1);
        hold(20, 0, 1'b0);
        rc(4'h2, 8'h06);
        rc(4'h0, 8'hfb);
        wr(4'h0, 8'h03);
        rc(4'h2, 8'h00);
        wr(4'h0, 8'h0b);
        hold(30, 0, 1'b0);
        rc(4'h2, 8'h06);
        wr(4'h4, 8'h03);
        rc(4'h2, 8'h00);
        wr(4'h4, 8'h01);
        wr(4'h3, 8'h70);
        wr(4'h0, 8'h0b);
        wt(1, 1'b1);
        while (pressure_i !== 8'h64) @(negedge core_clk_i);
        hold(5, 1, 1'b1);
        hold(15, 1, 1'b0);
        wr(4'h0, 8'h03);
        wr(4'h4, 8'h00);
        wr(4'h3, 8'h00);
        wr(4'h0, 8'h0b);
        hold(100, 0, 1'b1);
        wr(4'h0, 8'h1b);
        wt(1, 1'b1);
        wt(1, 1'b0);
        rc(4'h2, 8'h0f);
        wr(4'h0, 8'h0b);
        hold(5, 0, 1'b0);
        rc(4'h2, 8'h0f);
        wr(4'h0, 8'h08);
        rc(4'h2, 8'h07);
        wr(4'h0, 8'h00);
        rc(4'h2, 8'h00);
        wr(4'h3, 8'h20);
        wr(4'h0, 8'h09);
        wt(0, 1'b1);
        wt(0, 1'b0);
        chk({7'h0, pressure_i <= 8'h16 && pressure_i > 8'h10}, 8'h01);
        wr(4'h3, 8'h70);
        wt(1, 1'b1);
        wrap_up();
    end
endmodule : vacuum_gripper_command_regs_tb

// [dv/vacuum_gripper_properties.sv]
// Port-level checks on the gripper register bank.
`timescale 1ns/1ps
`include "gripper_defs.svh"
module vacuum_gripper_props #(
    parameter logic [`TICK_CNT_W-1:0] TICK_CYCLES = `TICK_CYCLES
) (
    input wire logic       core_clk_i,
    input wire logic       reset_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] pressure_i,
    input wire logic [7:0] rdata_o,
    input wire logic       vac_gen_on_o,
    input wire logic       release_valve_o
);
    // ========
    // Read port
    default clocking @(posedge core_clk_i);
    endclocking
    default disable iff (reset_i);
    AST_RD_IDLE: assert property (
        !$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside read cycle");
    AST_RD_LIVE: assert property (
        $past(rd_i) && $past(addr_i) == 4'h4 |-> rdata_o == $past(pressure_i))
        else $error("pressure read wrong");
    AST_RD_RSVD: assert property (
        $past(rd_i) && $past(addr_i) >= 4'h5 |-> rdata_o == 8'h00)
        else $error("reserved byte not zero");
    AST_RD_EXT: assert property (
        $past(rd_i) && $past(addr_i) == 4'h1 |-> rdata_o[7:2] == 6'h00)
        else $error("status extension upper bits set");
    AST_RD_FLT: assert property (
        $past(rd_i) && $past(addr_i) == 4'h2 |-> rdata_o[7:4] == 4'h0)
        else $error("fault upper bits set");
    // ========
    // Actuators
    AST_REG_OFF: assert property (
        wr_i && addr_i == 4'h0 && !wdata_i[3] && !wdata_i[4]
        |-> ##3 (!vac_gen_on_o && !release_valve_o) [*2])
        else $error("actuator on with regulate low");
    AST_DEACT: assert property (
        wr_i && addr_i == 4'h0 && !wdata_i[0]
        |-> ##[1:3] !vac_gen_on_o && !release_valve_o)
        else $error("actuator on while inactive");
    AST_ATR_OPEN: assert property (
        wr_i && addr_i == 4'h0 && wdata_i[0] && wdata_i[4] && pressure_i < 8'h64
        |-> ##[2:5] release_valve_o)
        else $error("release valve not opened");
    AST_ATR_NOGEN: assert property (
        wr_i && addr_i == 4'h0 && wdata_i[0] && wdata_i[4]
        |-> ##4 !vac_gen_on_o [*3])
        else $error("generator on during auto release");
endmodule : vacuum_gripper_props

bind vacuum_gripper_command_regs vacuum_gripper_props #(
    .TICK_CYCLES(TICK_CYCLES)
) u_props (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .pressure_i(pressure_i),
    .rdata_o(rdata_o), .vac_gen_on_o(vac_gen_on_o),
    .release_valve_o(release_valve_o)
);

// [dv/vacuum_plant.sv]
// Behavioural suction cup: the generator pulls vacuum, the valve vents.
`timescale 1ns/1ps
module vacuum_plant (
    input  wire logic       core_clk_i,
    input  wire logic       gen_on_i,
    input  wire logic       valve_open_i,
    output logic      [7:0] pressure_o
);
    logic [7:0] level = 8'h64;
    // The cup never pulls past 0x10, so a full vacuum target is never met.
    always @(posedge core_clk_i) begin
        if (gen_on_i && level > 8'h10)
            level <= level - 8'h01;
        else if (valve_open_i && level < 8'h64)
            level <= level + 8'h01;
    end
    assign pressure_o = level;
endmodule : vacuum_plant

// [rtl/gripper_defs.svh]
// Constants of the vacuum gripper command and status register bank.
`ifndef GRIPPER_DEFS_SVH
`define GRIPPER_DEFS_SVH

`define OFF_ACTION      4'h0
`define OFF_STATE       4'h0
`define OFF_STATE_EXT   4'h1
`define OFF_FAULT       4'h2
`define OFF_MAX         4'h3
`define OFF_TIMEOUT     4'h4
`define OFF_MIN         4'h5

`define ACT_BIT         0
`define MODE_LSB        1
`define MODE_MSB        2
`define REG_BIT         3
`define ATR_BIT         4

`define MODE_AUTO       2'h0
`define MODE_ADV        2'h1
`define AMBIENT_LEVEL   8'h64
`define AUTO_MAX_LEVEL  8'h16
`define AUTO_MIN_LEVEL  8'h5a
`define AUTO_GRIP_TICKS 8'h14
`define AUTO_REL_TICKS  8'h01

`define FLT_NONE        4'h0
`define FLT_TIMEOUT     4'h6
`define FLT_NOT_ACT     4'h7
`define FLT_ATR_RUN     4'hb
`define FLT_ATR_DONE    4'hf
`define OBJ_MOVING      2'h0
`define OBJ_MIN         2'h1
`define OBJ_MAX         2'h2
`define OBJ_NONE        2'h3
`define STA_OFF         2'h0
`define STA_ON          2'h3
`define VAS_STBY        2'h0
`define VAS_GRIP        2'h1
`define VAS_PASSIVE     2'h2

`define TICK_MS         100
`define CLK_KHZ         40000
`define TICK_CNT_W      22
// The product is 32 bits wide; the cast keeps it at the divider's width.
`define TICK_CYCLES     (22'(`TICK_MS * `CLK_KHZ))

`endif

// [rtl/gripper_pkg.sv]
// Types shared by the vacuum gripper modules.
package gripper_pkg;

    typedef enum logic [3:0] {
        ST_IDLE     = 4'h0,
        ST_STANDBY  = 4'h1,
        ST_GRIP     = 4'h3,
        ST_HOLD     = 4'h2,
        ST_RELEASE  = 4'h6,
        ST_REL_WAIT = 4'h7,
        ST_REL_DONE = 4'h5,
        ST_FAULT    = 4'h4,
        ST_ATR      = 4'hc,
        ST_ATR_DONE = 4'hd
    } ctl_state_t;

    typedef struct packed {
        logic [21:0] cnt;
        logic        tick;
    } div_state_t;

    typedef struct packed {
        logic [7:0] left;
        logic       run;
        logic       expired;
    } tmr_state_t;

endpackage : gripper_pkg

// [rtl/period_tick.sv]
// Divider that gives one-cycle ticks every 100 ms, realigned on each load.
`timescale 1ns/1ps
`include "gripper_defs.svh"
module period_tick
    import gripper_pkg::*;
#(
    parameter logic [`TICK_CNT_W-1:0] TICK_CYCLES = `TICK_CYCLES
) (
    input  wire logic core_clk_i,
    input  wire logic reset_i,
    window_if.divider win
);
    div_state_t div_reg;
    div_state_t div_next;

    always_comb begin
        div_next      = div_reg;
        div_next.tick = 1'b0;
        // Restarting on load makes the first window a full 100 ms.
        if (win.load) begin
            div_next.cnt = '0;
        end else if (div_reg.cnt == TICK_CYCLES - 22'h000001) begin
            div_next.cnt  = '0;
            div_next.tick = 1'b1;
        end else begin
            div_next.cnt = div_reg.cnt + 22'h000001;
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_next;
        end
    end

    assign win.tick = div_reg.tick;
endmodule : period_tick

// [rtl/vacuum_gripper_command_regs.sv]
// Register bank and actuator sequencer of the vacuum gripper.
`timescale 1ns/1ps
`include "gripper_defs.svh"
module vacuum_gripper_command_regs
    import gripper_pkg::*;
#(
    parameter logic [`TICK_CNT_W-1:0] TICK_CYCLES = `TICK_CYCLES
) (
    input  wire logic       core_clk_i,
    input  wire logic       reset_i,
    input  wire logic [3:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    input  wire logic [7:0] pressure_i,
    output logic      [7:0] rdata_o,
    output logic            vac_gen_on_o,
    output logic            release_valve_o
);

    // ========================================================================
    // State
    // ========================================================================
    typedef struct packed {
        logic       activate_request;
        logic [1:0] operating_mode_select;
        logic       regulate_request;
        logic       auto_release_request;
        logic [7:0] max_pressure_target;
        logic [7:0] grip_timeout_value;
        logic [7:0] min_pressure_target;
        ctl_state_t st;
        logic [1:0] object_detect_flag;
        logic [3:0] fault_code;
        logic       gen;
        logic       valve;
        logic [7:0] rdata;
        logic       load;
        logic [7:0] load_value;
    } ctl_t;

    ctl_t ctl_reg;
    ctl_t ctl_next;

    window_if win ();

    period_tick #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .win        (win)
    );

    window_timer u_timer (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .win        (win)
    );

    // ========================================================================
    // Helpers
    // ========================================================================
    // Lower code means deeper vacuum, so reaching a level is a less-or-equal.
    function automatic logic level_reached(input logic [7:0] p,
                                           input logic [7:0] level);
        level_reached = (p <= level);
    endfunction : level_reached

    function automatic logic is_adv(input logic [1:0] mode);
        is_adv = (mode == `MODE_ADV);
    endfunction : is_adv

    logic       adv;
    logic [7:0] tgt_max;
    logic [7:0] tgt_min;
    logic [7:0] grip_window;
    logic [7:0] rel_delay;
    logic       release_cmd;
    logic       at_ambient;
    logic       timed_out;
    logic       param_chg;
    logic [1:0] vas;
    logic       gto_echo;

    always_comb begin
        adv         = is_adv(ctl_reg.operating_mode_select);
        tgt_max     = adv ? ctl_reg.max_pressure_target : `AUTO_MAX_LEVEL;
        tgt_min     = adv ? ctl_reg.min_pressure_target : `AUTO_MIN_LEVEL;
        grip_window = adv ? ctl_reg.grip_timeout_value : `AUTO_GRIP_TICKS;
        rel_delay   = adv ? ctl_reg.grip_timeout_value : `AUTO_REL_TICKS;
        release_cmd = (ctl_reg.max_pressure_target >= `AMBIENT_LEVEL);
        at_ambient  = (pressure_i >= `AMBIENT_LEVEL);
        // A freshly issued load hides a stale expiry from the last window.
        timed_out   = win.expired && !ctl_reg.load;
        gto_echo    = ctl_reg.regulate_request && ctl_reg.activate_request;
        if (ctl_reg.gen) begin
            vas = `VAS_GRIP;
        end else if (ctl_reg.valve) begin
            vas = `VAS_PASSIVE;
        end else begin
            vas = `VAS_STBY;
        end
    end

    // Only a write that really changes a setting counts as a new order.
    always_comb begin
        param_chg = 1'b0;
        if (wr_i) begin
            unique case (addr_i)
                `OFF_ACTION:  param_chg = wdata_i[`MODE_MSB:`MODE_LSB] !=
                                  ctl_reg.operating_mode_select;
                `OFF_MAX:     param_chg =
                                  wdata_i != ctl_reg.max_pressure_target;
                `OFF_TIMEOUT: param_chg =
                                  wdata_i != ctl_reg.grip_timeout_value;
                `OFF_MIN:     param_chg =
                                  wdata_i != ctl_reg.min_pressure_target;
                default:      param_chg = 1'b0;
            endcase
        end
    end

    // ========================================================================
    // Next state
    // ========================================================================
    always_comb begin
        ctl_next       = ctl_reg;
        ctl_next.load  = 1'b0;
        ctl_next.rdata = 8'h00;

        // Register writes; reserved bits and bytes are dropped.
        if (wr_i) begin
            unique case (addr_i)
                `OFF_ACTION: begin
                    ctl_next.activate_request      = wdata_i[`ACT_BIT];
                    ctl_next.operating_mode_select =
                        wdata_i[`MODE_MSB:`MODE_LSB];
                    ctl_next.regulate_request      = wdata_i[`REG_BIT];
                    ctl_next.auto_release_request  = wdata_i[`ATR_BIT];
                end
                `OFF_MAX:     ctl_next.max_pressure_target = wdata_i;
                `OFF_TIMEOUT: ctl_next.grip_timeout_value  = wdata_i;
                `OFF_MIN:     ctl_next.min_pressure_target = wdata_i;
                default: ;
            endcase
        end

        // Status reads answer in the following cycle only.
        if (rd_i) begin
            unique case (addr_i)
                `OFF_STATE: ctl_next.rdata = {ctl_reg.object_detect_flag,
                    (ctl_reg.st == ST_IDLE) ? `STA_OFF : `STA_ON,
                    gto_echo, ctl_reg.operating_mode_select,
                    ctl_reg.activate_request};
                `OFF_STATE_EXT: ctl_next.rdata = {6'h00, vas};
                `OFF_FAULT:     ctl_next.rdata = {4'h0, ctl_reg.fault_code};
                `OFF_MAX:       ctl_next.rdata = ctl_reg.max_pressure_target;
                `OFF_TIMEOUT:   ctl_next.rdata = pressure_i;
                default:        ctl_next.rdata = 8'h00;
            endcase
        end

        // Sequencer.
        if (!ctl_reg.activate_request) begin
            ctl_next.st                 = ST_IDLE;
            ctl_next.gen                = 1'b0;
            ctl_next.valve              = 1'b0;
            ctl_next.object_detect_flag = `OBJ_MOVING;
            ctl_next.fault_code = ctl_reg.regulate_request ? `FLT_NOT_ACT
                                                           : `FLT_NONE;
        end else if (ctl_reg.auto_release_request &&
                     ctl_reg.st != ST_ATR && ctl_reg.st != ST_ATR_DONE) begin
            ctl_next.st         = ST_ATR;
            ctl_next.gen        = 1'b0;
            ctl_next.valve      = 1'b1;
            ctl_next.fault_code = `FLT_ATR_RUN;
        end else begin
            unique case (ctl_reg.st)
                ST_IDLE: begin
                    ctl_next.st         = ST_STANDBY;
                    ctl_next.fault_code = `FLT_NONE;
                end
                ST_STANDBY: begin
                    ctl_next.gen   = 1'b0;
                    ctl_next.valve = 1'b0;
                    if (ctl_reg.regulate_request) begin
                        ctl_next.object_detect_flag = `OBJ_MOVING;
                        if (release_cmd) begin
                            ctl_next.st    = ST_RELEASE;
                            ctl_next.valve = 1'b1;
                        end else begin
                            ctl_next.st         = ST_GRIP;
                            ctl_next.gen        = 1'b1;
                            ctl_next.load       = 1'b1;
                            ctl_next.load_value = grip_window;
                        end
                    end
                end
                ST_GRIP: begin
                    if (!ctl_reg.regulate_request) begin
                        ctl_next.st  = ST_STANDBY;
                        ctl_next.gen = 1'b0;
                    end else if (release_cmd) begin
                        ctl_next.st    = ST_RELEASE;
                        ctl_next.gen   = 1'b0;
                        ctl_next.valve = 1'b1;
                    end else if (tgt_max != 8'h00 &&
                                 level_reached(pressure_i, tgt_max)) begin
                        ctl_next.st                 = ST_HOLD;
                        ctl_next.gen                = 1'b0;
                        ctl_next.object_detect_flag = `OBJ_MAX;
                    end else if (level_reached(pressure_i, tgt_min)) begin
                        ctl_next.object_detect_flag = `OBJ_MIN;
                    end else if (ctl_reg.object_detect_flag == `OBJ_MOVING &&
                                 timed_out) begin
                        ctl_next.st                 = ST_FAULT;
                        ctl_next.gen                = 1'b0;
                        ctl_next.object_detect_flag = `OBJ_NONE;
                        ctl_next.fault_code         = `FLT_TIMEOUT;
                    end
                end
                ST_HOLD: begin
                    if (!ctl_reg.regulate_request) begin
                        ctl_next.st = ST_STANDBY;
                    end else if (release_cmd) begin
                        ctl_next.st    = ST_RELEASE;
                        ctl_next.valve = 1'b1;
                    end else if (!level_reached(pressure_i, tgt_min)) begin
                        // Leak past the minimum: pump again, no new window.
                        ctl_next.st                 = ST_GRIP;
                        ctl_next.gen                = 1'b1;
                        ctl_next.object_detect_flag = `OBJ_MIN;
                    end
                end
                ST_RELEASE: begin
                    if (!ctl_reg.regulate_request || !release_cmd) begin
                        ctl_next.st    = ST_STANDBY;
                        ctl_next.valve = 1'b0;
                    end else if (at_ambient) begin
                        ctl_next.object_detect_flag = `OBJ_NONE;
                        if (rel_delay == 8'h00) begin
                            ctl_next.st    = ST_REL_DONE;
                            ctl_next.valve = 1'b0;
                        end else begin
                            ctl_next.st         = ST_REL_WAIT;
                            ctl_next.load       = 1'b1;
                            ctl_next.load_value = rel_delay;
                        end
                    end
                end
                ST_REL_WAIT: begin
                    if (!ctl_reg.regulate_request) begin
                        ctl_next.st    = ST_STANDBY;
                        ctl_next.valve = 1'b0;
                    end else if (timed_out) begin
                        ctl_next.st    = ST_REL_DONE;
                        ctl_next.valve = 1'b0;
                    end
                end
                ST_REL_DONE: begin
                    if (!ctl_reg.regulate_request || !release_cmd) begin
                        ctl_next.st = ST_STANDBY;
                    end
                end
                ST_FAULT: begin
                    if (!ctl_reg.regulate_request || param_chg) begin
                        ctl_next.st         = ST_STANDBY;
                        ctl_next.fault_code = `FLT_NONE;
                    end
                end
                ST_ATR: begin
                    // The valve stays open until ambient; no window applies.
                    ctl_next.gen   = 1'b0;
                    ctl_next.valve = 1'b1;
                    if (at_ambient) begin
                        ctl_next.st         = ST_ATR_DONE;
                        ctl_next.valve      = 1'b0;
                        ctl_next.fault_code = `FLT_ATR_DONE;
                    end
                end
                ST_ATR_DONE: begin
                    // Left only when activate is cleared, which sends the sequencer back to idle.
                    ctl_next.gen   = 1'b0;
                    ctl_next.valve = 1'b0;
                end
                default: begin
                    ctl_next.st    = ST_IDLE;
                    ctl_next.gen   = 1'b0;
                    ctl_next.valve = 1'b0;
                end
            endcase
        end
    end

    // ========================================================================
    // Registers
    // ========================================================================
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            ctl_reg <= '0;
        end else begin
            ctl_reg <= ctl_next;
        end
    end

    assign win.load        = ctl_reg.load;
    assign win.load_value  = ctl_reg.load_value;
    assign rdata_o         = ctl_reg.rdata;
    assign vac_gen_on_o    = ctl_reg.gen;
    assign release_valve_o = ctl_reg.valve;

endmodule : vacuum_gripper_command_regs

// [rtl/window_if.sv]
// Carrier between the controller, the 100 ms divider and the window timer.
`timescale 1ns/1ps
interface window_if;
    logic       tick;
    logic       load;
    logic [7:0] load_value;
    logic       expired;

    modport divider (output tick, input load);
    modport timer   (input tick, input load, input load_value, output expired);
    modport ctrl    (output load, output load_value, input expired);
endinterface : window_if

// [rtl/window_timer.sv]
// Down counter of 100 ms ticks; a zero load leaves it idle.
`timescale 1ns/1ps
module window_timer
    import gripper_pkg::*;
(
    input  wire logic core_clk_i,
    input  wire logic reset_i,
    window_if.timer   win
);
    tmr_state_t tmr_reg;
    tmr_state_t tmr_next;

    always_comb begin
        tmr_next = tmr_reg;
        if (win.load) begin
            tmr_next.left    = win.load_value;
            tmr_next.run     = (win.load_value != 8'h00);
            tmr_next.expired = 1'b0;
        end else if (tmr_reg.run && win.tick) begin
            tmr_next.left = tmr_reg.left - 8'h01;
            if (tmr_reg.left == 8'h01) begin
                tmr_next.run     = 1'b0;
                tmr_next.expired = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            tmr_reg <= '0;
        end else begin
            tmr_reg <= tmr_next;
        end
    end

    assign win.expired = tmr_reg.expired;
endmodule : window_timer
